// >>> smbc_regs.svh
// Register map, field positions, reset values and timing counts of the serial bus configuration block
`ifndef SMBC_REGS_SVH
`define SMBC_REGS_SVH
`define SMBC_CFG_ADDR 8'hC1
`define SMBC_CFG_RESET 8'h00
`define SMBC_BIT_EN 7
`define SMBC_BIT_INH 6
`define SMBC_BIT_BUSY 5
`define SMBC_BIT_EXT 4
`define SMBC_BIT_TOE 3
`define SMBC_BIT_FTE 2
`define SMBC_CS_HI 1
`define SMBC_CS_LO 0
`define SMBC_HOLD_NORM 5'h03
`define SMBC_HOLD_EXT 5'h0C
`define SMBC_SETUP_NORM 5'h01
`define SMBC_SETUP_EXT 5'h0B
`define SMBC_DLY_MAX 5'h1F
`define SMBC_FREE_PERIODS 4'hA
`define SMBC_PHASE_TICKS 2'h2
`endif

// >>> smbc_pkg.sv
// Types shared by the serial bus configuration block
package smbc_pkg;
   typedef enum logic [2:0]
   {
      M_IDLE = 3'b001,
      M_LOW = 3'b010,
      M_HIGH = 3'b100
   } smbc_mstate_e;

   typedef enum logic [1:0]
   {
      SRC_T0 = 2'h0,
      SRC_T1 = 2'h1,
      SRC_T2_HI = 2'h2,
      SRC_T2_LO = 2'h3
   } smbc_clksrc_e;
endpackage : smbc_pkg

// >>> smbc_link_if.sv
// Signals passed from the link-clock line monitor to the system-clock logic
`timescale 1ns/1ps
interface smbc_link_if;
   logic scl_lvl;
   logic sda_lvl;
   logic start_tgl;
   logic stop_tgl;
   modport mon (output scl_lvl, output sda_lvl, output start_tgl, output stop_tgl);
   modport sys (input scl_lvl, input sda_lvl, input start_tgl, input stop_tgl);
endinterface : smbc_link_if

// >>> smbc_line_mon.sv
// Line monitor on the link clock: samples both bus lines and flags START and STOP
`timescale 1ns/1ps
module smbc_line_mon
   import smbc_pkg::*;
(
   input wire logic link_clock,
   input wire logic arst_n,
   input wire logic scl_i,
   input wire logic sda_i,
   smbc_link_if.mon lk
);
   logic scl_m_q, scl_m_d, scl_s_q, scl_s_d, sda_m_q, sda_m_d, sda_s_q, sda_s_d;
   logic scl_p_q, scl_p_d, sda_p_q, sda_p_d, start_t_q, start_t_d, stop_t_q, stop_t_d;

   // Two-stage pin synchronisers, then edge qualification on the settled copies
   always_comb
   begin
      scl_m_d = scl_i;
      sda_m_d = sda_i;
      scl_s_d = scl_m_q;
      sda_s_d = sda_m_q;
      scl_p_d = scl_s_q;
      sda_p_d = sda_s_q;
      start_t_d = start_t_q;
      stop_t_d = stop_t_q;
      // Data falling while clock stays high is a START; rising is a STOP
      if (scl_s_q && scl_p_q && sda_p_q && !sda_s_q)
         start_t_d = !start_t_q;
      if (scl_s_q && scl_p_q && !sda_p_q && sda_s_q)
         stop_t_d = !stop_t_q;
   end

   always_ff @(posedge link_clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         scl_m_q <= 1'b1;
         sda_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         sda_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         start_t_q <= 1'b0;
         stop_t_q <= 1'b0;
      end
      else
      begin
         scl_m_q <= scl_m_d;
         sda_m_q <= sda_m_d;
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         start_t_q <= start_t_d;
         stop_t_q <= stop_t_d;
      end
   end

   // Events cross as toggles, so a START is never lost to a slow system clock
   assign lk.scl_lvl = scl_s_q;
   assign lk.sda_lvl = sda_s_q;
   assign lk.start_tgl = start_t_q;
   assign lk.stop_tgl = stop_t_q;
endmodule : smbc_line_mon

// >>> smbc_config.sv
// Serial bus port configuration register, busy tracking, timeouts and master clock pacing
`timescale 1ns/1ps
`include "smbc_regs.svh"
module smbc_config
   import smbc_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clock_en,
   input wire logic link_clock,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic timer0_ovf,
   input wire logic timer1_ovf,
   input wire logic timer2_hi_ovf,
   input wire logic timer2_lo_ovf,
   input wire logic aux_timer_split,
   output logic aux_reload_hi,
   output logic aux_reload_lo,
   input wire logic slave_event,
   output logic slave_irq,
   output logic slave_nack_force,
   input wire logic master_go,
   input wire logic master_sda_bit,
   output logic master_scl_fall,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   smbc_link_if lk ();

   smbc_line_mon u_mon
   (
      .link_clock(link_clock),
      .arst_n(arst_n),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .lk(lk)
   );

   // Pick the bit-rate tick from the four overflow pulses
   function automatic logic pick_tick(input logic [1:0] sel, input logic t0, input logic t1,
                                      input logic t2h, input logic t2l);
      unique case (smbc_clksrc_e'(sel))
         SRC_T0: pick_tick = t0;
         SRC_T1: pick_tick = t1;
         SRC_T2_HI: pick_tick = t2h;
         SRC_T2_LO: pick_tick = t2l;
      endcase
   endfunction : pick_tick

   logic [7:0] cfg_q, cfg_d, rdata_q, rdata_d;
   logic [1:0] scl_sy_q, scl_sy_d, sda_sy_q, sda_sy_d;
   logic [2:0] st_sy_q, st_sy_d, sp_sy_q, sp_sy_d;
   logic busy_q, busy_d, tick_q, tick_d, inh_act_q, inh_act_d, irq_q, irq_d, nack_q, nack_d;
   logic rl_hi_q, rl_hi_d, rl_lo_q, rl_lo_d, fall_q, fall_d;
   logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d, pin_low_q;
   logic [3:0] free_q, free_d;
   logic [1:0] mtk_q, mtk_d;
   logic [4:0] dly_q, dly_d, hold_cnt, setup_cnt;
   smbc_mstate_e ms_q, ms_d;
   logic en, start_ev, stop_ev, scl_hi, sda_hi;

   // Decoded control fields and crossed link events
   always_comb
   begin
      en = cfg_q[`SMBC_BIT_EN];
      scl_hi = scl_sy_q[1];
      sda_hi = sda_sy_q[1];
      start_ev = st_sy_q[2] ^ st_sy_q[1];
      stop_ev = sp_sy_q[2] ^ sp_sy_q[1];
      hold_cnt = cfg_q[`SMBC_BIT_EXT] ? `SMBC_HOLD_EXT : `SMBC_HOLD_NORM;
      setup_cnt = cfg_q[`SMBC_BIT_EXT] ? `SMBC_SETUP_EXT : `SMBC_SETUP_NORM;
   end

   // Configuration register, read port, busy, free timeout, inhibit and timer control
   always_comb
   begin
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      // Second stage only feeds the edge/level users, first stage feeds only the second
      scl_sy_d = {scl_sy_q[0], lk.scl_lvl};
      sda_sy_d = {sda_sy_q[0], lk.sda_lvl};
      st_sy_d = {st_sy_q[1:0], lk.start_tgl};
      sp_sy_d = {sp_sy_q[1:0], lk.stop_tgl};
      tick_d = pick_tick(cfg_q[`SMBC_CS_HI:`SMBC_CS_LO], timer0_ovf, timer1_ovf,
                         timer2_hi_ovf, timer2_lo_ovf);
      busy_d = busy_q;
      free_d = free_q;
      inh_act_d = inh_act_q;
      if (sfr_wr && sfr_addr == `SMBC_CFG_ADDR)
      begin
         cfg_d = sfr_wdata;
         cfg_d[`SMBC_BIT_BUSY] = 1'b0; // Busy is read-only
      end
      if (sfr_rd)
      begin
         rdata_d = 8'h00;
         if (sfr_addr == `SMBC_CFG_ADDR)
         begin
            rdata_d = cfg_q;
            rdata_d[`SMBC_BIT_BUSY] = busy_q;
         end
      end
      // Free timeout counts ticks only while both lines stay high
      if (!(scl_hi && sda_hi) || !cfg_q[`SMBC_BIT_FTE])
         free_d = 4'h0;
      else if (tick_q && free_q <= `SMBC_FREE_PERIODS)
         free_d = free_q + 4'h1;
      // Clear first so that a START in the same cycle wins
      if (stop_ev || free_q > `SMBC_FREE_PERIODS)
         busy_d = 1'b0;
      if (en && (start_ev || ms_q != M_IDLE))
         busy_d = 1'b1;
      // Inhibit takes hold only at a START, the current transfer keeps its interrupts
      if (start_ev)
         inh_act_d = cfg_q[`SMBC_BIT_INH];
      if (!en)
      begin
         busy_d = 1'b0;
         free_d = 4'h0;
      end
      irq_d = en && slave_event && !inh_act_q;
      nack_d = en && inh_act_q;
      rl_hi_d = en && cfg_q[`SMBC_BIT_TOE] && scl_hi;
      rl_lo_d = en && cfg_q[`SMBC_BIT_TOE] && scl_hi && !aux_timer_split;
   end

   // Master clock pacing with data hold and setup spacing
   always_comb
   begin
      ms_d = ms_q;
      mtk_d = mtk_q;
      dly_d = dly_q;
      scl_oe_n_d = scl_oe_n_q;
      sda_oe_n_d = sda_oe_n_q;
      fall_d = 1'b0;
      unique case (ms_q)
         M_IDLE:
         begin
            if (en && master_go)
            begin
               ms_d = M_LOW;
               mtk_d = 2'h0;
               dly_d = 5'h00;
               scl_oe_n_d = 1'b0;
               fall_d = 1'b1;
            end
         end
         M_LOW:
         begin
            if (dly_q != `SMBC_DLY_MAX)
               dly_d = dly_q + 5'h01;
            if (tick_q && mtk_q != `SMBC_PHASE_TICKS)
               mtk_d = mtk_q + 2'h1;
            // New data only after the hold time has passed
            if (dly_q == hold_cnt)
               sda_oe_n_d = master_sda_bit;
            // First tick is partial, so two ticks give at least one full period
            if (mtk_q == `SMBC_PHASE_TICKS && dly_q >= hold_cnt + setup_cnt)
            begin
               ms_d = M_HIGH;
               mtk_d = 2'h0;
               scl_oe_n_d = 1'b1;
            end
         end
         M_HIGH:
         begin
            // High time counts only once the line is really high, honouring stretching
            if (tick_q && scl_hi && mtk_q != `SMBC_PHASE_TICKS)
               mtk_d = mtk_q + 2'h1;
            if (mtk_q == `SMBC_PHASE_TICKS)
            begin
               ms_d = master_go ? M_LOW : M_IDLE;
               mtk_d = 2'h0;
               dly_d = 5'h00;
               scl_oe_n_d = !master_go;
               fall_d = master_go;
            end
         end
      endcase
      if (!en)
      begin
         ms_d = M_IDLE;
         scl_oe_n_d = 1'b1;
         sda_oe_n_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_q <= `SMBC_CFG_RESET;
         rdata_q <= 8'h00;
         scl_sy_q <= 2'h3;
         sda_sy_q <= 2'h3;
         st_sy_q <= 3'h0;
         sp_sy_q <= 3'h0;
         tick_q <= 1'b0;
         busy_q <= 1'b0;
         free_q <= 4'h0;
         inh_act_q <= 1'b0;
         irq_q <= 1'b0;
         nack_q <= 1'b0;
         rl_hi_q <= 1'b0;
         rl_lo_q <= 1'b0;
         ms_q <= M_IDLE;
         mtk_q <= 2'h0;
         dly_q <= 5'h00;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
         fall_q <= 1'b0;
         pin_low_q <= 1'b0;
      end
      else if (clock_en)
      begin
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
         scl_sy_q <= scl_sy_d;
         sda_sy_q <= sda_sy_d;
         st_sy_q <= st_sy_d;
         sp_sy_q <= sp_sy_d;
         tick_q <= tick_d;
         busy_q <= busy_d;
         free_q <= free_d;
         inh_act_q <= inh_act_d;
         irq_q <= irq_d;
         nack_q <= nack_d;
         rl_hi_q <= rl_hi_d;
         rl_lo_q <= rl_lo_d;
         ms_q <= ms_d;
         mtk_q <= mtk_d;
         dly_q <= dly_d;
         scl_oe_n_q <= scl_oe_n_d;
         sda_oe_n_q <= sda_oe_n_d;
         fall_q <= fall_d;
         pin_low_q <= 1'b0;
      end
   end

   // Open-drain pins: the value is always low, the enable decides
   assign sfr_rdata = rdata_q;
   assign aux_reload_hi = rl_hi_q;
   assign aux_reload_lo = rl_lo_q;
   assign slave_irq = irq_q;
   assign slave_nack_force = nack_q;
   assign master_scl_fall = fall_q;
   assign scl_o = pin_low_q;
   assign sda_o = pin_low_q;
   assign scl_oe_n = scl_oe_n_q;
   assign sda_oe_n = sda_oe_n_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   busy_set_a: assert property (clock_en && en && start_ev |=> busy_q)
      else $error("busy not set after START");
   busy_clear_a: assert property (clock_en && stop_ev && !start_ev && ms_q == M_IDLE |=> !busy_q)
      else $error("busy not cleared by STOP");
   free_clear_a: assert property (clock_en && free_q > `SMBC_FREE_PERIODS && !start_ev && ms_q == M_IDLE
                                  |=> !busy_q)
      else $error("busy not cleared by free timeout");
   inhibit_irq_a: assert property (clock_en && inh_act_q |=> !slave_irq)
      else $error("slave interrupt while inhibited");
   nack_start_a: assert property (clock_en && en && start_ev && cfg_q[`SMBC_BIT_INH] ##1 clock_en && en
                                  |=> slave_nack_force)
      else $error("inhibit not applied at START");
   hold_data_a: assert property (clock_en && ms_q == M_LOW && dly_q < hold_cnt && en
                                 |=> $stable(sda_oe_n))
      else $error("data changed inside hold time");
   setup_rise_a: assert property (ms_q == M_LOW && ms_d == M_HIGH |-> dly_q >= hold_cnt + setup_cnt)
      else $error("clock released before setup time");
   phase_ticks_a: assert property (ms_q == M_LOW && ms_d == M_HIGH |-> mtk_q == `SMBC_PHASE_TICKS)
      else $error("low phase shorter than one period");
   reload_hold_a: assert property (clock_en && en && cfg_q[`SMBC_BIT_TOE] && scl_hi
                                   |=> aux_reload_hi && (aux_reload_lo == !$past(aux_timer_split)))
      else $error("aux timer not held in reload");
   split_free_a: assert property (clock_en && aux_timer_split |=> !aux_reload_lo)
      else $error("low byte reloaded in split mode");
   tick_select_a: assert property (clock_en |=> tick_q == pick_tick($past(cfg_q[1:0]), $past(timer0_ovf),
                                   $past(timer1_ovf), $past(timer2_hi_ovf), $past(timer2_lo_ovf)))
      else $error("wrong bit-rate source");
   disable_idle_a: assert property (clock_en && !en |=> ms_q == M_IDLE && scl_oe_n && sda_oe_n && !busy_q)
      else $error("disable did not idle the port");
endmodule : smbc_config

// >>> smbc_peer_model.sv
// Far-side bus party: makes START and STOP and can hold the clock line low
`timescale 1ns/1ps
module smbc_peer_model
(
   input wire logic link_clock,
   output logic scl_oe_n,
   output logic sda_oe_n
);
   // Open drain: released lines rise through the bench pull-up
   initial
   begin
      scl_oe_n = 1'b1;
      sda_oe_n = 1'b1;
   end

   // Set both line drivers, then let them settle for a few link clocks
   task automatic step(input logic c, input logic d);
      @(posedge link_clock);
      scl_oe_n <= c;
      sda_oe_n <= d;
      repeat (4) @(posedge link_clock);
   endtask : step

   // START, then lines end high without a STOP (data released while clock low)
   task automatic start_idle();
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
   endtask : start_idle

   // STOP: data rises while clock is high
   task automatic stop_cond();
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : stop_cond
endmodule : smbc_peer_model

// >>> smbc_testbench.sv
// Self-checking bench for the serial bus configuration block
`timescale 1ns/1ps
`include "smbc_regs.svh"
module testbench;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic [3:0] tmr = 4'h0;
   logic split = 1'b0;
   logic slave_event = 1'b0;
   logic master_go = 1'b0;
   logic master_sda_bit = 1'b0;
   logic clock_en = 1'b1;
   logic slave_irq, slave_nack_force, master_scl_fall, aux_reload_hi, aux_reload_lo;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, peer_scl_oe_n, peer_sda_oe_n;
   wire scl_w = (scl_oe_n | scl_o) & peer_scl_oe_n;
   wire sda_w = (sda_oe_n | sda_o) & peer_sda_oe_n;
   int mismatches = 0;
   int n_checks = 0;

   always #5 clock = ~clock;
   // Link clock offset so its edges drift against the system clock
   initial
   begin
      #2.3;
      forever #6 link_clock = ~link_clock;
   end

   smbc_config DUT (.clock(clock), .arst_n(arst_n), .clock_en(clock_en), .link_clock(link_clock),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]), .timer2_hi_ovf(tmr[2]), .timer2_lo_ovf(tmr[3]),
      .aux_timer_split(split), .aux_reload_hi(aux_reload_hi), .aux_reload_lo(aux_reload_lo),
      .slave_event(slave_event), .slave_irq(slave_irq), .slave_nack_force(slave_nack_force),
      .master_go(master_go), .master_sda_bit(master_sda_bit), .master_scl_fall(master_scl_fall),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

   smbc_peer_model peer (.link_clock(link_clock), .scl_oe_n(peer_scl_oe_n), .sda_oe_n(peer_sda_oe_n));

   task automatic end_sim();
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
         mismatches++;
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr

   // Read data is registered, so it is taken just after the edge that follows the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      #1 d = sfr_rdata;
   endtask : rd

   // Line events cross two clock domains, so busy is polled under a bound
   task automatic wait_busy(input logic exp);
      logic [7:0] d;
      for (int i = 0; i < 60; i++)
      begin
         rd(`SMBC_CFG_ADDR, d);
         if (d[5] === exp)
            return;
      end
      mismatches++;
      end_sim();
   endtask : wait_busy

   task automatic tick(input logic [3:0] m);
      @(posedge clock);
      tmr <= m;
      @(posedge clock);
      tmr <= 4'h0;
      cyc(3);
   endtask : tick

   task automatic slave_pulse(output logic seen);
      seen = 1'b0;
      @(posedge clock);
      slave_event <= 1'b1;
      @(posedge clock);
      slave_event <= 1'b0;
      repeat (4)
      begin
         @(posedge clock);
         seen = seen | slave_irq;
      end
   endtask : slave_pulse

   task automatic t_regs();
      logic [7:0] d;
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h00);
      wr(`SMBC_CFG_ADDR, 8'h7F);
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h5F);
      rd(8'hC0, d);
      check(d, 8'h00);
      wr(8'hC2, 8'hFF);
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h5F);
      wr(`SMBC_CFG_ADDR, 8'h00);
      // A frozen block must ignore a write strobe, or enable could come on behind the core's back
      @(posedge clock);
      clock_en <= 1'b0;
      wr(`SMBC_CFG_ADDR, 8'h80);
      @(posedge clock);
      clock_en <= 1'b1;
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h00);
   endtask : t_regs

   task automatic t_busy();
      logic [7:0] d;
      peer.start_idle();
      cyc(30);
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h00);
      peer.stop_cond();
      wr(`SMBC_CFG_ADDR, 8'h80);
      peer.start_idle();
      wait_busy(1'b1);
      peer.stop_cond();
      wait_busy(1'b0);
   endtask : t_busy

   // Free timeout per source: other overflows must not count, the eleventh selected one frees
   task automatic t_free();
      logic [7:0] d;
      for (int s = 0; s < 4; s++)
      begin
         wr(`SMBC_CFG_ADDR, 8'h84 | 8'(s));
         peer.start_idle();
         wait_busy(1'b1);
         cyc(10);
         for (int k = 0; k < 12; k++)
            tick(4'hF & ~(4'h1 << s));
         for (int k = 0; k < 10; k++)
            tick(4'h1 << s);
         rd(`SMBC_CFG_ADDR, d);
         check(d, 8'hA4 | 8'(s));
         tick(4'h1 << s);
         rd(`SMBC_CFG_ADDR, d);
         check(d, 8'h84 | 8'(s));
      end
   endtask : t_free

   task automatic t_inhibit();
      logic s;
      logic [7:0] d;
      wr(`SMBC_CFG_ADDR, 8'h80);
      slave_pulse(s);
      check({7'h0, s}, 8'h01);
      wr(`SMBC_CFG_ADDR, 8'hC0);
      slave_pulse(s);
      check({7'h0, s}, 8'h01);
      check({7'h0, slave_nack_force}, 8'h00);
      peer.start_idle();
      wait_busy(1'b1);
      slave_pulse(s);
      check({7'h0, s}, 8'h00);
      check({7'h0, slave_nack_force}, 8'h01);
      wr(`SMBC_CFG_ADDR, 8'h40);
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h40);
      peer.stop_cond();
   endtask : t_inhibit

   task automatic t_aux();
      logic [7:0] d;
      wr(`SMBC_CFG_ADDR, 8'h88);
      cyc(8);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h03);
      @(posedge clock);
      split <= 1'b1;
      cyc(4);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h02);
      peer.step(1'b0, 1'b1);
      cyc(8);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h00);
      peer.step(1'b1, 1'b1);
      cyc(8);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h02);
      wr(`SMBC_CFG_ADDR, 8'h80);
      cyc(3);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h00);
      split <= 1'b0;
      // Clock stuck low inside a transfer: the timeout handler restarts the port by a disable and re-enable
      wr(`SMBC_CFG_ADDR, 8'h88);
      peer.step(1'b1, 1'b0);
      peer.step(1'b0, 1'b0);
      wait_busy(1'b1);
      wr(`SMBC_CFG_ADDR, 8'h08);
      wr(`SMBC_CFG_ADDR, 8'h88);
      rd(`SMBC_CFG_ADDR, d);
      check(d, 8'h88);
      check({6'h0, aux_reload_hi, aux_reload_lo}, 8'h00);
      peer.stop_cond();
      wr(`SMBC_CFG_ADDR, 8'h80);
   endtask : t_aux

   // Master clocking with a tick every 20 cycles: measure hold, setup and both phases
   task automatic t_master(input logic ext);
      int tf, ts, tr, tf2, falls;
      logic po, pd;
      tf = 0;
      ts = 0;
      tr = 0;
      tf2 = 0;
      falls = 0;
      po = 1'b1;
      pd = 1'b1;
      wr(`SMBC_CFG_ADDR, ext ? 8'h90 : 8'h80);
      @(posedge clock);
      master_go <= 1'b1;
      for (int i = 1; i < 600; i++)
      begin
         @(posedge clock);
         tmr <= {3'h0, i % 20 == 0};
         falls += int'(master_scl_fall === 1'b1);
         if (po === 1'b1 && scl_oe_n === 1'b0 && tf == 0)
            tf = i;
         else if (po === 1'b1 && scl_oe_n === 1'b0 && tr != 0 && tf2 == 0)
            tf2 = i;
         if (pd === 1'b1 && sda_oe_n === 1'b0 && ts == 0)
            ts = i;
         if (po === 1'b0 && scl_oe_n === 1'b1 && tr == 0)
            tr = i;
         po = scl_oe_n;
         pd = sda_oe_n;
      end
      tmr <= 4'h0;
      check({7'h0, ts - tf >= (ext ? 12 : 3)}, 8'h01);
      check({7'h0, tr - ts >= (ext ? 11 : 1)}, 8'h01);
      check({7'h0, tr - tf >= 20}, 8'h01);
      check({7'h0, tf2 - tr >= 20}, 8'h01);
      check({7'h0, falls >= 2}, 8'h01);
      check({6'h0, scl_o, sda_o}, 8'h00);
      wr(`SMBC_CFG_ADDR, 8'h00);
      cyc(3);
      check({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
      master_go <= 1'b0;
   endtask : t_master

   initial
   begin
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      cyc(4);
      t_regs();
      t_busy();
      t_free();
      t_inhibit();
      t_aux();
      t_master(1'b0);
      t_master(1'b1);
      end_sim();
   end
endmodule : testbench
